// ### verilog/apms_pkg.sv
// constants and types for the activity power mode sequencer
// ----------------------------------------------------------------------------
// Summary of operation
// - power mode requests come from software controls and from packet logic
// - separate power-down outputs for transmit, receive, synthesizer and amplifier
// - packet logic powers rf sections only while a packet needs them
// - connection low-power mode runs on slow oscillator, wakes after fixed period
// - four power states: active, idle, sleep, deep power-off
// - programmable inactivity period steps down to next lower state
// - activity in any lower state returns straight to active
// - entering deep power-off disables the core regulator output only while FW_REG_OFF_EN_IN is set
// - always-on io domain watches events and restores power on one
// - firmware control can disable the regulator in deep sleep
// - reset pin active low, open-drain drive, pull-up, accepts external low
// - high test-mode select enters test mode; tie low when unused
// ----------------------------------------------------------------------------
package apms_pkg;

  typedef enum logic [1:0] {
    APMS_ACTIVE,
    APMS_IDLE,
    APMS_SLEEP,
    APMS_DEEP_OFF
  } apms_state_type;

  localparam int unsigned TIMER_WIDTH         = 32;
  localparam int unsigned CONN_WIDTH          = 24;
  localparam int unsigned ACT_WIDTH           = 4;
  localparam logic [31:0] IDLE_TIMEOUT_RESET  = 32'h0000_4E20;
  localparam logic [31:0] SLEEP_TIMEOUT_RESET = 32'h0001_86A0;
  localparam logic [31:0] OFF_TIMEOUT_RESET   = 32'h0098_9680;
  localparam logic [23:0] CONN_WAKE_RESET     = 24'h00_1000;
  // reset pulse driven on the pin, in nanoseconds, and its cycle count at 5 ns
  localparam int unsigned CLK_PERIOD_NS       = 5;
  localparam int unsigned RESET_PULSE_NS      = 1000;
  localparam int unsigned RESET_PULSE_CYCLES  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ### verilog/apms_sync_if.sv
// interface carrying synchronised activity and test levels
`timescale 1ns/1ps
interface apms_sync_if;
  logic [apms_pkg::ACT_WIDTH-1:0] activity;
  logic                           test_mode;
  logic                           reset_ext;
  modport source (output activity, output test_mode, output reset_ext);
  modport sink   (input activity, input test_mode, input reset_ext);
endinterface

// ### verilog/apms_input_sync.sv
// two-stage synchroniser for activity, test and reset-pin inputs
`timescale 1ns/1ps
module apms_input_sync (
  input  wire logic                           clk_in,
  input  wire logic                           resetn_in,
  input  wire logic [apms_pkg::ACT_WIDTH-1:0] activity_in,
  input  wire logic                           test_mode_in,
  input  wire logic                           reset_pin_in,
  apms_sync_if.source                         sync
);

  logic [apms_pkg::ACT_WIDTH+1:0] stage1;
  logic [apms_pkg::ACT_WIDTH+1:0] stage2;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= {~reset_pin_in, test_mode_in, activity_in};
      stage2 <= stage1;
    end
  end

  assign sync.activity  = stage2[apms_pkg::ACT_WIDTH-1:0];
  assign sync.test_mode = stage2[apms_pkg::ACT_WIDTH];
  assign sync.reset_ext = stage2[apms_pkg::ACT_WIDTH+1];

endmodule

// ### verilog/apms_top.sv
// activity driven power mode sequencer with rf power-down control
`timescale 1ns/1ps
module apms_top (
  input  wire logic                           CLK_SYS_IN,
  input  wire logic                           RESETN_IN,
  input  wire logic [apms_pkg::ACT_WIDTH-1:0] ACTIVITY_IN,
  input  wire logic                           TEST_MODE_SELECT_IN,
  input  wire logic                           RESET_PIN_IN,
  input  wire logic                           FW_RESET_REQ_IN,
  input  wire logic                           SW_MODE_REQ_IN,
  input  wire logic [1:0]                     SW_MODE_IN,
  input  wire logic                           PKT_SLEEP_REQ_IN,
  input  wire logic                           PKT_TX_ON_IN,
  input  wire logic                           PKT_RX_ON_IN,
  input  wire logic                           FW_REG_OFF_EN_IN,
  input  wire logic [31:0]                    IDLE_TIMEOUT_IN,
  input  wire logic [31:0]                    SLEEP_TIMEOUT_IN,
  input  wire logic [31:0]                    OFF_TIMEOUT_IN,
  input  wire logic [23:0]                    CONN_WAKE_IN,
  output logic [1:0]                          POWER_STATE_OUT,
  output logic                                TX_PD_OUT,
  output logic                                RX_PD_OUT,
  output logic                                PLL_PD_OUT,
  output logic                                PA_PD_OUT,
  output logic                                CORE_REG_EN_OUT,
  output logic                                LOW_POWER_OSC_SEL_OUT,
  output logic                                CONN_WAKE_OUT,
  output logic                                TEST_MODE_OUT,
  output logic                                SYS_RESETN_OUT,
  output logic                                RESET_PIN_OUT,
  output logic                                RESET_PIN_OE_N_OUT
);

  apms_sync_if sync ();

  apms_input_sync u_sync (
    .clk_in       (CLK_SYS_IN),
    .resetn_in    (RESETN_IN),
    .activity_in  (ACTIVITY_IN),
    .test_mode_in (TEST_MODE_SELECT_IN),
    .reset_pin_in (RESET_PIN_IN),
    .sync         (sync)
  );

  // --------------------------------------------------------------------------
  // activity edge detection
  // --------------------------------------------------------------------------
  logic [apms_pkg::ACT_WIDTH-1:0] act_prev;
  logic                           activity_event;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      act_prev <= '0;
    end else begin
      act_prev <= sync.activity;
    end
  end

  assign activity_event = |(sync.activity & ~act_prev);

  // --------------------------------------------------------------------------
  // power mode state machine
  // --------------------------------------------------------------------------
  apms_pkg::apms_state_type state;
  apms_pkg::apms_state_type next_state;
  logic [apms_pkg::TIMER_WIDTH-1:0] idle_cnt;
  logic [apms_pkg::TIMER_WIDTH-1:0] limit;
  logic                             expired;
  logic                             conn_mode;

  always_comb begin
    unique case (state)
      apms_pkg::APMS_ACTIVE: limit = IDLE_TIMEOUT_IN;
      apms_pkg::APMS_IDLE:   limit = SLEEP_TIMEOUT_IN;
      apms_pkg::APMS_SLEEP:  limit = OFF_TIMEOUT_IN;
      apms_pkg::APMS_DEEP_OFF: limit = '1;
    endcase
  end

  assign expired = (idle_cnt >= limit) && (state != apms_pkg::APMS_DEEP_OFF);

  always_comb begin
    next_state = state;
    if (activity_event) begin
      next_state = apms_pkg::APMS_ACTIVE;
    end else if (SW_MODE_REQ_IN) begin
      next_state = apms_pkg::apms_state_type'(SW_MODE_IN);
    end else if (PKT_SLEEP_REQ_IN && state == apms_pkg::APMS_ACTIVE) begin
      next_state = apms_pkg::APMS_IDLE;
    end else if (expired) begin
      unique case (state)
        apms_pkg::APMS_ACTIVE: next_state = apms_pkg::APMS_IDLE;
        apms_pkg::APMS_IDLE:   next_state = apms_pkg::APMS_SLEEP;
        apms_pkg::APMS_SLEEP:  next_state = apms_pkg::APMS_DEEP_OFF;
        apms_pkg::APMS_DEEP_OFF: next_state = apms_pkg::APMS_DEEP_OFF;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      state <= apms_pkg::APMS_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      idle_cnt <= '0;
    end else if (activity_event || next_state != state) begin
      idle_cnt <= '0;
    end else if (!expired) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // low-power connection wake timer
  // --------------------------------------------------------------------------
  logic [apms_pkg::CONN_WIDTH-1:0] conn_cnt;

  assign conn_mode = (state == apms_pkg::APMS_SLEEP);

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      conn_cnt      <= '0;
      CONN_WAKE_OUT <= 1'b0;
    end else if (conn_mode && next_state == state) begin
      if (conn_cnt >= CONN_WAKE_IN) begin
        conn_cnt      <= '0;
        CONN_WAKE_OUT <= 1'b1;
      end else begin
        conn_cnt      <= conn_cnt + 1'b1;
        CONN_WAKE_OUT <= 1'b0;
      end
    end else begin
      conn_cnt      <= '0;
      CONN_WAKE_OUT <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // power and rf control outputs
  // --------------------------------------------------------------------------
  logic radio_live;
  logic deep_next;

  assign radio_live = (next_state == apms_pkg::APMS_ACTIVE) || (next_state == apms_pkg::APMS_IDLE);
  assign deep_next  = (next_state == apms_pkg::APMS_DEEP_OFF);

  // driven from next_state so every control lands together with the state output
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      POWER_STATE_OUT       <= 2'h0;
      CORE_REG_EN_OUT       <= 1'b1;
      LOW_POWER_OSC_SEL_OUT <= 1'b0;
    end else begin
      POWER_STATE_OUT       <= 2'(next_state);
      CORE_REG_EN_OUT       <= !(deep_next && FW_REG_OFF_EN_IN);
      LOW_POWER_OSC_SEL_OUT <= (next_state == apms_pkg::APMS_SLEEP) || deep_next;
    end
  end

  // --------------------------------------------------------------------------
  // rf power-down controls, gated per packet
  // --------------------------------------------------------------------------
  // amplifier follows transmit; synthesizer serves both paths
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      TX_PD_OUT  <= 1'b1;
      RX_PD_OUT  <= 1'b1;
      PLL_PD_OUT <= 1'b1;
      PA_PD_OUT  <= 1'b1;
    end else begin
      TX_PD_OUT  <= !(radio_live && PKT_TX_ON_IN);
      RX_PD_OUT  <= !(radio_live && PKT_RX_ON_IN);
      PLL_PD_OUT <= !(radio_live && (PKT_TX_ON_IN || PKT_RX_ON_IN));
      PA_PD_OUT  <= !(radio_live && PKT_TX_ON_IN);
    end
  end

  // --------------------------------------------------------------------------
  // reset pin
  // --------------------------------------------------------------------------
  logic [9:0] rst_cnt;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      rst_cnt <= '0;
    end else if (FW_RESET_REQ_IN) begin
      rst_cnt <= 10'(apms_pkg::RESET_PULSE_CYCLES);
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      RESET_PIN_OUT      <= 1'b0;
      RESET_PIN_OE_N_OUT <= 1'b1;
      SYS_RESETN_OUT     <= 1'b0;
    end else begin
      RESET_PIN_OUT      <= 1'b0;
      // released while the count reads one, so the pin stays low for the full count
      RESET_PIN_OE_N_OUT <= !(FW_RESET_REQ_IN || rst_cnt > 10'h001);
      SYS_RESETN_OUT     <= !sync.reset_ext && rst_cnt == '0;
    end
  end

  // --------------------------------------------------------------------------
  // test mode select
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      TEST_MODE_OUT <= 1'b0;
    end else begin
      TEST_MODE_OUT <= sync.test_mode;
    end
  end

endmodule

// ### tb/apms_assertions.sv
// port checker for the power mode sequencer
`timescale 1ns/1ps
module apms_assertions (
  input wire logic                           CLK_SYS_IN,
  input wire logic                           RESETN_IN,
  input wire logic [apms_pkg::ACT_WIDTH-1:0] ACTIVITY_IN,
  input wire logic                           TEST_MODE_SELECT_IN,
  input wire logic                           SW_MODE_REQ_IN,
  input wire logic [1:0]                     POWER_STATE_OUT,
  input wire logic                           TX_PD_OUT,
  input wire logic                           RX_PD_OUT,
  input wire logic                           PLL_PD_OUT,
  input wire logic                           PA_PD_OUT,
  input wire logic                           CORE_REG_EN_OUT,
  input wire logic                           CONN_WAKE_OUT,
  input wire logic                           TEST_MODE_OUT,
  input wire logic                           RESET_PIN_OE_N_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  logic [8:0] low_cnt;
  // cycles the pin has been driven low
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN || RESET_PIN_OE_N_OUT) low_cnt <= 9'h000;
    else low_cnt <= low_cnt + 9'h001;
  end
  sequence s_act_rise;
    (ACTIVITY_IN & ~$past(ACTIVITY_IN)) != 4'h0;
  endsequence
  sequence s_deep_held;
    POWER_STATE_OUT == 2'h3 ##1 POWER_STATE_OUT == 2'h3;
  endsequence
  a_act_wake: assert property (s_act_rise |-> ##4 POWER_STATE_OUT == 2'h0)
    else $error("activity did not restore active state");
  a_step_down: assert property (!$past(SW_MODE_REQ_IN) && !$past(SW_MODE_REQ_IN, 2)
    && POWER_STATE_OUT > $past(POWER_STATE_OUT) |-> POWER_STATE_OUT == $past(POWER_STATE_OUT) + 2'h1)
    else $error("state skipped a level going down");
  a_deep_pd: assert property (s_deep_held |-> TX_PD_OUT && RX_PD_OUT && PLL_PD_OUT && PA_PD_OUT)
    else $error("radio powered in deep off");
  a_radio_up: assert property (!TX_PD_OUT || !RX_PD_OUT |-> POWER_STATE_OUT < 2'h2 || $past(POWER_STATE_OUT) < 2'h2)
    else $error("radio path on in a sleep state");
  a_reg_off: assert property (!CORE_REG_EN_OUT |-> POWER_STATE_OUT == 2'h3 || $past(POWER_STATE_OUT) == 2'h3)
    else $error("regulator off outside deep off");
  a_wake_pulse: assert property (CONN_WAKE_OUT |=> !CONN_WAKE_OUT)
    else $error("wake pulse longer than one cycle");
  a_test_lat: assert property ($rose(TEST_MODE_SELECT_IN) |-> ##3 TEST_MODE_OUT)
    else $error("test mode not entered in time");
  a_pin_pulse: assert property ($rose(RESET_PIN_OE_N_OUT) |-> low_cnt == 9'(apms_pkg::RESET_PULSE_CYCLES))
    else $error("reset pin pulse length wrong");
endmodule
bind apms_top apms_assertions chk (.CLK_SYS_IN, .RESETN_IN, .ACTIVITY_IN, .TEST_MODE_SELECT_IN, .SW_MODE_REQ_IN,
  .POWER_STATE_OUT, .TX_PD_OUT, .RX_PD_OUT, .PLL_PD_OUT, .PA_PD_OUT, .CORE_REG_EN_OUT, .CONN_WAKE_OUT,
  .TEST_MODE_OUT, .RESET_PIN_OE_N_OUT);

// ### tb/apms_radio_model.sv
// radio power-down inputs and reset pin of the far side
`timescale 1ns/1ps
module apms_radio_model (
  input  wire logic clk_in,
  input  wire logic tx_pd_in,
  input  wire logic rx_pd_in,
  input  wire logic pll_pd_in,
  input  wire logic pa_pd_in,
  input  wire logic pin_drv_in,
  input  wire logic pin_oe_n_in,
  input  wire logic ext_low_in,
  output logic      tx_live_out,
  output logic      rx_live_out,
  output logic      pin_out
);
  // pull-up wins unless a party pulls low
  assign pin_out = !ext_low_in && (pin_oe_n_in || pin_drv_in);
  // a path runs only with the synthesizer up
  always_ff @(posedge clk_in) begin
    tx_live_out <= !tx_pd_in && !pll_pd_in && !pa_pd_in;
    rx_live_out <= !rx_pd_in && !pll_pd_in;
  end
endmodule

// ### tb/activity_power_mode_sequencer_tb.sv
// bench for the activity power mode sequencer
`timescale 1ns/1ps
module activity_power_mode_sequencer_tb;
  logic clk = 1'b0, rstn = 1'b0, tsel = 1'b0, ext_low = 1'b0, fw_req = 1'b0, sw_req = 1'b0;
  logic pkt_sleep = 1'b0, pkt_tx = 1'b0, pkt_rx = 1'b0, reg_off = 1'b1;
  logic [3:0] act = 4'h0;
  logic [1:0] sw_mode = 2'h0, st;
  logic tx_pd, rx_pd, pll_pd, pa_pd, reg_en, osc, wake, tmode, sysrn, pin_drv, oe_n, pin, tx_live, rx_live;
  logic [7:0] lfsr = 8'h3E;
  int fails = 0, checks = 0, cyc = 0, n, exp_st;
  always #2.5 clk = ~clk;
  apms_top uut (.CLK_SYS_IN(clk), .RESETN_IN(rstn), .ACTIVITY_IN(act), .TEST_MODE_SELECT_IN(tsel),
    .RESET_PIN_IN(pin), .FW_RESET_REQ_IN(fw_req), .SW_MODE_REQ_IN(sw_req), .SW_MODE_IN(sw_mode),
    .PKT_SLEEP_REQ_IN(pkt_sleep), .PKT_TX_ON_IN(pkt_tx), .PKT_RX_ON_IN(pkt_rx), .FW_REG_OFF_EN_IN(reg_off),
    .IDLE_TIMEOUT_IN(32'h0000_0014), .SLEEP_TIMEOUT_IN(32'h0000_001E), .OFF_TIMEOUT_IN(32'h0000_0028),
    .CONN_WAKE_IN(24'h00_0008), .POWER_STATE_OUT(st), .TX_PD_OUT(tx_pd), .RX_PD_OUT(rx_pd),
    .PLL_PD_OUT(pll_pd), .PA_PD_OUT(pa_pd), .CORE_REG_EN_OUT(reg_en), .LOW_POWER_OSC_SEL_OUT(osc),
    .CONN_WAKE_OUT(wake), .TEST_MODE_OUT(tmode), .SYS_RESETN_OUT(sysrn), .RESET_PIN_OUT(pin_drv),
    .RESET_PIN_OE_N_OUT(oe_n));
  apms_radio_model radio (.clk_in(clk), .tx_pd_in(tx_pd), .rx_pd_in(rx_pd), .pll_pd_in(pll_pd),
    .pa_pd_in(pa_pd), .pin_drv_in(pin_drv), .pin_oe_n_in(oe_n), .ext_low_in(ext_low),
    .tx_live_out(tx_live), .rx_live_out(rx_live), .pin_out(pin));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_st(logic [1:0] s, int lim);
    n = 0;
    while (st !== s && n < 500) begin
      tick(1);
      n++;
    end
    chk(n >= lim - 1 && n <= lim + 4, 1);
  endtask
  task conclude();
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      conclude();
    end
  end
  initial begin
    tick(4);
    chk({st, tx_pd, rx_pd, pll_pd, pa_pd, reg_en, oe_n, sysrn}, 9'h07E);
    rstn = 1'b1;
    wait_st(2'h1, 20);
    wait_st(2'h2, 30);
    chk(osc, 1);
    while (!wake) tick(1);
    tick(1);
    for (n = 1; !wake && n < 50; n++) tick(1);
    // wake counter runs from zero up to the period, inclusive
    chk(n, 9);
    // two wake periods of sleep already spent
    wait_st(2'h3, 40 - 2 * 9);
    tick(1);
    chk({reg_en, osc, tx_pd, rx_pd, pll_pd, pa_pd}, 6'h1F);
    n = rnd();
    act = 4'h1 << n[1:0];
    tick(2);
    chk(st, 3);
    tick(1);
    chk({st, reg_en}, 3'h1);
    repeat (8) begin
      act = 4'(rnd()) | 4'h1;
      tick(5);
      act = 4'h0;
      tick(5);
    end
    chk(st, 0);
    for (int m = 1; m < 5; m++) begin
      exp_st = m % 4;
      sw_mode = 2'(exp_st);
      sw_req = 1'b1;
      tick(1);
      sw_req = 1'b0;
      tick(2);
      chk(st, exp_st);
    end
    pkt_tx = 1'b1;
    tick(3);
    chk({tx_pd, rx_pd, pll_pd, pa_pd, tx_live}, 5'h09);
    pkt_tx = 1'b0;
    pkt_rx = 1'b1;
    tick(3);
    chk({tx_pd, rx_pd, pll_pd, pa_pd, rx_live}, 5'h13);
    pkt_rx = 1'b0;
    pkt_sleep = 1'b1;
    tick(1);
    pkt_sleep = 1'b0;
    tick(2);
    chk(st, 1);
    tsel = 1'b1;
    tick(2);
    chk(tmode, 0);
    tick(1);
    chk(tmode, 1);
    tsel = 1'b0;
    fw_req = 1'b1;
    tick(1);
    fw_req = 1'b0;
    for (n = 0; pin && n < 10; n++) tick(1);
    for (n = 0; !pin && n < 400; n++) tick(1);
    chk(n, apms_pkg::RESET_PULSE_CYCLES);
    ext_low = 1'b1;
    tick(5);
    chk(sysrn, 0);
    ext_low = 1'b0;
    tick(5);
    chk(sysrn, 1);
    conclude();
  end
endmodule
